// ---- core/device_switch.sv ----
// Purpose: device switch controller of a dual-processor redundancy unit
// Assumes: straps, keys and fault lines are asynchronous pins
// Notes: copies are issued as request words; the copy engine acks each
// Functional notes
// RULE1: backup-return active: copy register 254 backup to master every sweep
// RULE2: range-copy active: copy master start..end registers into backup each sweep
// RULE3: output-table active: copy output status and transition tables each sweep
// RULE4: full-transfer first position: bulk copy when a processor becomes backup
// RULE5: full-transfer other position: only selected copies plus default ones
// RULE6: backup flag sits at input 1024, or 1022 in alternate strap position
// RULE7: scan-limit strap picks 150 ms or 250 ms supervision limit
// RULE8: each copy option also selectable by master table bits
// RULE9: input table and timer time-base copied every sweep regardless
// RULE10: exactly one master indicator lit, first or second processor
// RULE11: normal status codes 0 to 3 show I/O redundancy and aux chain
// RULE12: error codes 4 to 9 show hung bus and card failures
// RULE13: status digit flashes on watchdog timeout: hold, cpu fail, errors 5-9
// RULE14: twelve relays to normally-closed on first, normally-open on second
// RULE15: watchdog and status outputs give external error indication
// RULE16: timeout stays latched until fault clears and reset or run return
`timescale 1ns/1ns
`include "device_switch_regs.svh"

module device_switch
  import device_switch_pkg::*;
#(
  parameter int unsigned SCAN_SHORT = `SCAN_SHORT_CYCLES,
  parameter int unsigned SCAN_LONG = `SCAN_LONG_CYCLES,
  parameter int unsigned FLASH_HALF = 62500000
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic backupReturnStrap,
  input wire logic rangeCopyStrap,
  input wire logic outputTableStrap,
  input wire logic fullTransferStrap,
  input wire logic backupFlagPlaceStrap,
  input wire logic scanLimitStrap,
  input wire logic holdSelected,
  input wire logic masterIsSecond,
  input wire logic redundantIo,
  input wire logic auxIoChain,
  input wire logic processorFail,
  input wire logic copyAck,
  output logic copyReq,
  output logic [3:0] copyKind,
  output logic [15:0] copyFirst,
  output logic [15:0] copyLast,
  output logic [15:0] backupFlagInput,
  output logic firstMasterLed,
  output logic secondMasterLed,
  output logic [11:0] relayToNormallyOpen,
  output logic [3:0] statusDigit,
  output logic statusBlank,
  output logic watchdogTimeout
);

  // ==================================================
  // pin synchronisers
  localparam int NPIN = 11;
  logic [NPIN-1:0] pinRaw;
  logic [NPIN-1:0] pinMeta_q;
  logic [NPIN-1:0] pinSync_q;
  assign pinRaw = {processorFail, auxIoChain, redundantIo, masterIsSecond,
                   holdSelected, scanLimitStrap, backupFlagPlaceStrap,
                   fullTransferStrap, outputTableStrap, rangeCopyStrap,
                   backupReturnStrap};
  always_ff @(posedge clk) begin
    pinMeta_q <= pinRaw;
    pinSync_q <= pinMeta_q;
  end
  wire sBackupReturn = pinSync_q[0];
  wire sRangeCopy = pinSync_q[1];
  wire sOutputTable = pinSync_q[2];
  wire sFullTransfer = pinSync_q[3];
  wire sFlagAlt = pinSync_q[4];
  wire sScanLong = pinSync_q[5];
  wire sHold = pinSync_q[6];
  wire sSecond = pinSync_q[7];
  wire sRedundant = pinSync_q[8];
  wire sAux = pinSync_q[9];
  wire sProcFail = pinSync_q[10];

  // ==================================================
  // apb slave, zero wait states
  logic [31:0] ctrl_q;
  logic [31:0] copySel_q;
  logic [15:0] rangeStart_q;
  logic [15:0] rangeEnd_q;
  logic [31:0] sweepCount_q;
  wire apbAccess = psel & penable;
  wire apbWrite = apbAccess & pwrite;
  wire hitCtrl = paddr == `CTRL_OFFSET;
  wire hitStatus = paddr == `STATUS_OFFSET;
  wire hitSel = paddr == `COPY_SEL_OFFSET;
  wire hitRange = paddr == `RANGE_OFFSET;
  wire hitSweep = paddr == `SWEEP_OFFSET;
  wire hitAny = hitCtrl | hitStatus | hitSel | hitRange | hitSweep;
  wire sweepPulse = apbWrite & hitCtrl & pwdata[`CTRL_SWEEP_BIT];
  wire backupEvt = apbWrite & hitCtrl & pwdata[`CTRL_BACKUP_EVT_BIT];
  wire returnRun = apbWrite & hitCtrl & pwdata[`CTRL_RETURN_RUN_BIT];
  assign pready = 1'b1;
  assign pslverr = apbAccess & ~hitAny;

  logic [31:0] statusWord;
  logic [31:0] readMux;
  assign readMux = hitCtrl ? ctrl_q :
                   hitStatus ? statusWord :
                   hitSel ? copySel_q :
                   hitRange ? {rangeEnd_q, rangeStart_q} :
                   hitSweep ? sweepCount_q : 32'h00000000;
  assign prdata = readMux;

  // pulse bits are not stored; only the error field persists
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_q <= `CTRL_RESET_VALUE;
      copySel_q <= `COPY_SEL_RESET_VALUE;
      rangeStart_q <= 16'h0000;
      rangeEnd_q <= 16'h0000;
    end else if (apbWrite) begin
      if (hitCtrl)
        ctrl_q <= {23'h000000, pwdata[8:4], 4'h0};
      if (hitSel)
        copySel_q <= {28'h0000000, pwdata[3:0]};
      if (hitRange) begin
        rangeStart_q <= pwdata[15:0];
        rangeEnd_q <= pwdata[31:16];
      end
    end
  end

  // ==================================================
  // copy option selection
  wire optReturn = sBackupReturn | copySel_q[`SEL_BACKUP_RETURN_BIT]; // RULE8
  wire optRange = sRangeCopy | copySel_q[`SEL_RANGE_COPY_BIT]; // RULE8
  wire optOutput = sOutputTable | copySel_q[`SEL_OUTPUT_TABLE_BIT]; // RULE8
  // strap low is the first position: bulk copy on becoming backup
  wire optFull = ~sFullTransfer | copySel_q[`SEL_FULL_TRANSFER_BIT]; // RULE8

  // ==================================================
  // copy sequencer; one request per enabled step, kinds:
  // 0 input table, 1 time base, 2 reg254 back, 3 range, 4 output tables,
  // 5 full registers, 6 full tables
  copy_state_t state_q;
  logic [2:0] step_q;
  logic pendFull_q;
  logic stepEnabled;
  logic [2:0] lastStep;
  always_comb begin
    stepEnabled = 1'b1; // RULE9
    case (step_q)
      3'd2: stepEnabled = optReturn; // RULE1
      3'd3: stepEnabled = optRange; // RULE2
      3'd4: stepEnabled = optOutput; // RULE3 RULE5
      default: stepEnabled = 1'b1;
    endcase
  end
  assign lastStep = (state_q == COPY_FULL) ? 3'd6 : 3'd4;
  wire stepDone = ~stepEnabled | copyAck;

  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= COPY_IDLE;
      step_q <= 3'd0;
      pendFull_q <= 1'b0;
      sweepCount_q <= 32'h00000000;
    end else begin
      case (state_q)
        COPY_IDLE: begin
          if (pendFull_q) begin
            state_q <= COPY_FULL; // RULE4
            step_q <= 3'd5;
            pendFull_q <= 1'b0;
          end else if (sweepPulse) begin
            state_q <= COPY_SWEEP;
            step_q <= 3'd0;
          end
        end
        COPY_SWEEP, COPY_FULL: begin
          if (stepDone) begin
            if (step_q == lastStep)
              state_q <= COPY_DONE;
            else
              step_q <= step_q + 3'd1;
          end
        end
        COPY_DONE: begin
          state_q <= COPY_IDLE;
          sweepCount_q <= sweepCount_q + 32'h00000001;
        end
        default: state_q <= COPY_IDLE;
      endcase
      // set after the take, so an event in that same cycle is not lost
      if (backupEvt & optFull)
        pendFull_q <= 1'b1; // RULE4
    end
  end

  wire busy = (state_q == COPY_SWEEP) | (state_q == COPY_FULL);
  assign copyReq = busy & stepEnabled;
  assign copyKind = {1'b0, step_q};
  always_comb begin
    copyFirst = 16'h0000;
    copyLast = 16'h0000;
    case (step_q)
      3'd2: begin
        copyFirst = `BACKUP_RETURN_REG; // RULE1
        copyLast = `BACKUP_RETURN_REG;
      end
      3'd3: begin
        copyFirst = rangeStart_q; // RULE2
        copyLast = rangeEnd_q;
      end
      3'd5: begin
        copyFirst = 16'h0000;
        copyLast = `FULL_REG_LIMIT - 16'd1; // RULE4
      end
      default: begin
        copyFirst = 16'h0000;
        copyLast = 16'h0000;
      end
    endcase
  end

  // ==================================================
  // backup flag, relays, master indicators
  always_ff @(posedge clk) begin
    if (rst) begin
      backupFlagInput <= `BACKUP_BIT_DEFAULT;
      firstMasterLed <= 1'b1;
      secondMasterLed <= 1'b0;
      relayToNormallyOpen <= 12'h000;
    end else begin
      backupFlagInput <= sFlagAlt ? `BACKUP_BIT_ALTERNATE
                                  : `BACKUP_BIT_DEFAULT; // RULE6
      firstMasterLed <= ~sSecond; // RULE10
      secondMasterLed <= sSecond; // RULE10
      relayToNormallyOpen <= {12{sSecond}}; // RULE14
    end
  end

  // ==================================================
  // scan supervision: a sweep must arrive within the selected limit
  logic [31:0] scanCount_q;
  wire [31:0] scanLimit = sScanLong ? SCAN_LONG : SCAN_SHORT; // RULE7
  wire scanOver = scanCount_q >= scanLimit;
  always_ff @(posedge clk) begin
    if (rst | sweepPulse | sHold)
      scanCount_q <= 32'h00000000;
    else if (!scanOver)
      scanCount_q <= scanCount_q + 32'h00000001;
  end

  // ==================================================
  // status digit and watchdog
  wire [4:0] errBits = ctrl_q[`CTRL_ERR_LSB +: `CTRL_ERR_WIDTH];
  // error bits: 0 hung bus, 1 storage, 2 prom, 3 data control, 4 cpu switch
  wire selfFail = scanOver;
  wire hardErr = |errBits[4:1] | selfFail;
  wire wdCause = sHold | sProcFail | hardErr; // RULE13
  logic [3:0] digit;
  always_comb begin
    digit = {2'b00, sAux, sRedundant}; // RULE11
    if (errBits[0])
      digit = CODE_HUNG_BUS; // RULE12
    if (errBits[1])
      digit = CODE_STORAGE;
    if (errBits[2])
      digit = CODE_PROM;
    if (errBits[3])
      digit = CODE_DATA_CTRL;
    if (selfFail)
      digit = CODE_SWITCH_CARD;
    if (errBits[4])
      digit = CODE_PROC_SWITCH;
  end

  logic wd_q;
  always_ff @(posedge clk) begin
    if (rst)
      wd_q <= 1'b0;
    else if (wdCause)
      wd_q <= 1'b1; // RULE15
    else if (returnRun)
      wd_q <= 1'b0; // RULE16
  end
  assign watchdogTimeout = wd_q;

  logic [31:0] flashCount_q;
  logic flashPhase_q;
  always_ff @(posedge clk) begin
    if (rst | ~wd_q) begin
      flashCount_q <= 32'h00000000;
      flashPhase_q <= 1'b0;
    end else if (flashCount_q >= FLASH_HALF - 1) begin
      flashCount_q <= 32'h00000000;
      flashPhase_q <= ~flashPhase_q; // RULE13
    end else begin
      flashCount_q <= flashCount_q + 32'h00000001;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      statusDigit <= 4'h0;
      statusBlank <= 1'b0;
    end else begin
      statusDigit <= digit;
      statusBlank <= flashPhase_q;
    end
  end

  assign statusWord = {16'h0000, sweepCount_q[3:0], 3'b000, wd_q,
                       3'b000, busy, digit};

endmodule

// ---- core/device_switch_pkg.sv ----
// Purpose: types of the device switch controller
// Assumes: nothing
// Notes: none
package device_switch_pkg;

  // ==================================================
  // copy sequencer states
  typedef enum logic [3:0] {
    COPY_IDLE = 4'h1,
    COPY_SWEEP = 4'h2,
    COPY_FULL = 4'h4,
    COPY_DONE = 4'h8
  } copy_state_t;

  // status digit codes
  typedef enum logic [3:0] {
    CODE_SINGLE = 4'h0,
    CODE_REDUNDANT = 4'h1,
    CODE_SINGLE_AUX = 4'h2,
    CODE_REDUNDANT_AUX = 4'h3,
    CODE_HUNG_BUS = 4'h4,
    CODE_STORAGE = 4'h5,
    CODE_PROM = 4'h6,
    CODE_DATA_CTRL = 4'h7,
    CODE_SWITCH_CARD = 4'h8,
    CODE_PROC_SWITCH = 4'h9
  } status_code_t;

endpackage

// ---- core/device_switch_regs.svh ----
// Purpose: register offsets, field positions, reset values and timing counts
// Assumes: apb with 32-bit data, word-aligned registers
// Notes: offsets are byte addresses
`ifndef DEVICE_SWITCH_REGS_SVH
`define DEVICE_SWITCH_REGS_SVH

// ==================================================
// register offsets
`define CTRL_OFFSET 12'h000
`define STATUS_OFFSET 12'h004
`define COPY_SEL_OFFSET 12'h008
`define RANGE_OFFSET 12'h00C
`define SWEEP_OFFSET 12'h010

// ==================================================
// control fields
`define CTRL_RESET_VALUE 32'h00000000
`define CTRL_SWEEP_BIT 0
`define CTRL_BACKUP_EVT_BIT 1
`define CTRL_RETURN_RUN_BIT 2
`define CTRL_ERR_LSB 4
`define CTRL_ERR_WIDTH 5

// ==================================================
// copy-select fields (table-bit alternative to the straps)
`define COPY_SEL_RESET_VALUE 32'h00000000
`define SEL_BACKUP_RETURN_BIT 0
`define SEL_RANGE_COPY_BIT 1
`define SEL_OUTPUT_TABLE_BIT 2
`define SEL_FULL_TRANSFER_BIT 3

// ==================================================
// copy constants
`define BACKUP_RETURN_REG 16'd254
`define RANGE_START_REG 16'd255
`define RANGE_END_REG 16'd256
`define FULL_REG_LIMIT 16'd4096
`define BACKUP_BIT_DEFAULT 16'd1024
`define BACKUP_BIT_ALTERNATE 16'd1022

// ==================================================
// timing
`define CLK_FREQ_HZ 125000000
`define SCAN_SHORT_MS 150
`define SCAN_LONG_MS 250
`define SCAN_SHORT_CYCLES (`CLK_FREQ_HZ / 1000 * `SCAN_SHORT_MS)
`define SCAN_LONG_CYCLES (`CLK_FREQ_HZ / 1000 * `SCAN_LONG_MS)

`endif

// ---- test/copy_engine_model.sv ----
// Purpose: copy engine answering copy request steps
// Assumes: one ack pulse ends each step
// Notes: lag sets stall cycles before each ack
`timescale 1ns/1ns
module copy_engine_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic copyReq,
  input wire logic [1:0] lag,
  output logic copyAck
);
  // ====
  // ack pulse after a variable stall
  logic [1:0] waitQ;
  always_ff @(posedge clk) begin
    if (rst || copyAck || !copyReq) begin
      copyAck <= 1'b0;
      waitQ <= '0;
    end else if (waitQ >= lag) begin
      copyAck <= 1'b1;
    end else begin
      waitQ <= waitQ + 2'h1;
    end
  end
endmodule

// ---- test/device_switch_checker.sv ----
// Purpose: port checks of the device switch
// Assumes: FLASH_HALF equals the instance value
// Notes: pin effects lag by the two sync flops
`timescale 1ns/1ns
`include "device_switch_regs.svh"
module device_switch_checker #(
  parameter int unsigned FLASH_HALF = 4
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic holdSelected,
  input wire logic backupFlagPlaceStrap,
  input wire logic copyReq,
  input wire logic copyAck,
  input wire logic [3:0] copyKind,
  input wire logic [15:0] backupFlagInput,
  input wire logic firstMasterLed,
  input wire logic secondMasterLed,
  input wire logic [11:0] relayToNormallyOpen,
  input wire logic [3:0] statusDigit,
  input wire logic statusBlank,
  input wire logic watchdogTimeout
);
  // ====
  // helpers
  wire clearWr = psel && penable && pwrite && paddr == `CTRL_OFFSET
    && pwdata[`CTRL_RETURN_RUN_BIT];
  logic blankQ;
  logic [31:0] stillQ;
  // counts cycles the digit has not flashed while timed out
  always_ff @(posedge clk) begin
    blankQ <= statusBlank;
    if (rst || !watchdogTimeout || statusBlank != blankQ) begin
      stillQ <= '0;
    end else begin
      stillQ <= stillQ + 32'h1;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence holdLong;
    holdSelected [*4];
  endsequence
  sequence stalled;
    copyReq && !copyAck;
  endsequence
  AST_ONE_LED: assert property (firstMasterLed != secondMasterLed)
    else $error("master leds not exclusive");
  AST_RELAYS: assert property (
    relayToNormallyOpen == {12{secondMasterLed}})
    else $error("relays disagree with master");
  AST_FLAG: assert property (backupFlagInput ==
    ($past(backupFlagPlaceStrap, 3) ? `BACKUP_BIT_ALTERNATE
    : `BACKUP_BIT_DEFAULT))
    else $error("backup flag place wrong");
  AST_DIGIT: assert property (statusDigit <= 4'h9)
    else $error("status digit out of range");
  AST_HOLD: assert property (holdLong |-> ##[0:4] watchdogTimeout)
    else $error("hold gave no timeout");
  AST_LATCH: assert property ($fell(watchdogTimeout) |->
    $past(rst) || $past(clearWr))
    else $error("timeout dropped without clear");
  AST_FLASH: assert property (stillQ <= FLASH_HALF + 1)
    else $error("digit not flashing");
  AST_REQ_HOLD: assert property (
    stalled |=> copyReq && $stable(copyKind))
    else $error("copy request dropped before ack");
endmodule

// ---- test/tb_device_switch.sv ----
// Purpose: self-checking bench of the device switch
// Assumes: short scan limits of 200 and 300 cycles
// Notes: copy steps are noted in a queue and matched on ack
`timescale 1ns/1ns
`include "device_switch_regs.svh"
module tb_device_switch;
  import device_switch_pkg::*;
  logic clk, rst, psel, penable, pwrite, pready, pslverr, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic backupReturnStrap, rangeCopyStrap, outputTableStrap;
  logic fullTransferStrap, backupFlagPlaceStrap, scanLimitStrap;
  logic holdSelected, masterIsSecond, redundantIo, auxIoChain;
  logic processorFail, copyAck, copyReq, firstMasterLed;
  logic secondMasterLed, statusBlank, watchdogTimeout;
  logic [3:0] copyKind, statusDigit;
  logic [15:0] copyFirst, copyLast, backupFlagInput, rStart, rEnd;
  logic [11:0] relayToNormallyOpen;
  logic [1:0] lag;
  logic [3:0] sel;
  logic [35:0] notes[$];
  int n_errors, checks_done;
  // ====
  // design and partner
  device_switch #(.SCAN_SHORT(200), .SCAN_LONG(300), .FLASH_HALF(4))
    u_dut (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .backupReturnStrap, .rangeCopyStrap,
    .outputTableStrap, .fullTransferStrap, .backupFlagPlaceStrap,
    .scanLimitStrap, .holdSelected, .masterIsSecond, .redundantIo,
    .auxIoChain, .processorFail, .copyAck, .copyReq, .copyKind,
    .copyFirst, .copyLast, .backupFlagInput, .firstMasterLed,
    .secondMasterLed, .relayToNormallyOpen, .statusDigit, .statusBlank,
    .watchdogTimeout);
  copy_engine_model u_eng (.clk, .rst, .copyReq, .lag, .copyAck);
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic report_and_stop();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d);
    @(posedge clk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge clk);
    penable <= 1'b1;
    // only the watchdog ends a wait for pready
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic clr();
    chk({31'h0, watchdogTimeout}, 32'h1);
    wr(`CTRL_OFFSET, 32'h4);
    repeat (2) @(posedge clk);
    chk({31'h0, watchdogTimeout}, 32'h0);
  endtask
  // a sweep pulse, with a became-backup event close behind when ev
  task automatic sweep(input logic ev);
    int n;
    logic [2:0] en;
    n = 0;
    en = sel[2:0] | {outputTableStrap, rangeCopyStrap, backupReturnStrap};
    notes.push_back({4'h0, 32'h0});
    notes.push_back({4'h1, 32'h0});
    for (int k = 0; k < 3; k++)
      if (en[k]) notes.push_back({4'(k + 2), rEnd, rStart});
    if (ev && (!fullTransferStrap || sel[3])) begin
      notes.push_back({4'h5, 32'h0});
      notes.push_back({4'h6, 32'h0});
    end
    wr(`CTRL_OFFSET, 32'h1);
    if (ev) wr(`CTRL_OFFSET, 32'h2);
    while (notes.size() > 0 && n < 300) begin
      @(posedge clk);
      n++;
    end
    repeat (8) @(posedge clk);
    chk(32'(notes.size()), 32'h0);
  endtask
  always @(posedge clk) begin
    logic [35:0] nt;
    if (!rst && copyReq === 1'b1 && copyAck === 1'b1) begin
      nt = 36'hF_FFFF_FFFF;
      if (notes.size() > 0) nt = notes.pop_front();
      chk({28'h0, copyKind}, {28'h0, nt[35:32]});
      if (nt[35:32] == 4'h3) chk({copyLast, copyFirst}, nt[31:0]);
      if (nt[35:32] == 4'h2)
        chk({copyLast, copyFirst}, {2{`BACKUP_RETURN_REG}});
      if (nt[35:32] == 4'h5)
        chk({copyLast, copyFirst}, {`FULL_REG_LIMIT - 16'd1, 16'h0});
    end
  end
  initial begin
    repeat (60000) @(posedge clk);
    n_errors++;
    report_and_stop();
  end
  initial begin
    {psel, penable, pwrite, paddr, pwdata, lag, sel} = '0;
    {backupReturnStrap, rangeCopyStrap, outputTableStrap} = 3'h0;
    {holdSelected, processorFail, masterIsSecond, redundantIo} = 4'h0;
    {auxIoChain, backupFlagPlaceStrap, scanLimitStrap} = 3'h0;
    {fullTransferStrap, rStart, rEnd} = {1'b1, 32'h0};
    {n_errors, checks_done} = {32'h0, 32'h0};
    rst = 1'b1;
    void'($urandom(32'hE1E84BA3));
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      {auxIoChain, redundantIo} <= i[1:0];
      {backupFlagPlaceStrap, masterIsSecond} <= i[1:0];
      sweep(1'b0);
      chk({28'h0, statusDigit}, 32'(i));
      chk({secondMasterLed, firstMasterLed}, i[0] ? 2 : 1);
      chk({20'h0, relayToNormallyOpen}, i[0] ? 32'hFFF : 0);
      chk({16'h0, backupFlagInput}, i[1] ? `BACKUP_BIT_ALTERNATE
        : `BACKUP_BIT_DEFAULT);
    end
    for (int i = 0; i < 8; i++) begin
      {outputTableStrap, rangeCopyStrap, backupReturnStrap}
        <= i[0] ? 3'($urandom) : 3'h0;
      sel = i[0] ? 4'h0 : 4'($urandom);
      lag <= 2'($urandom);
      rStart = 16'($urandom % 4000);
      rEnd = rStart + 16'($urandom % 96);
      wr(`COPY_SEL_OFFSET, {28'h0, sel});
      wr(`RANGE_OFFSET, {rEnd, rStart});
      sweep(1'b0);
    end
    apb(1'b0, `COPY_SEL_OFFSET, 32'h0);
    chk(rd, {28'h0, sel});
    apb(1'b0, 12'h020, 32'h0);
    chk({er, rd[30:0]}, 32'h8000_0000);
    // twelve sweeps so far, digit 3, idle, no timeout
    apb(1'b0, `SWEEP_OFFSET, 32'h0);
    chk(rd, 32'h0000000C);
    apb(1'b0, `STATUS_OFFSET, 32'h0);
    chk(rd, 32'h0000C003);
    for (int i = 0; i < 3; i++) begin
      fullTransferStrap <= i > 0;
      if (i == 2) begin
        sel = 4'h8;
        wr(`COPY_SEL_OFFSET, {28'h0, sel});
      end
      repeat (4) @(posedge clk);
      sweep(1'b1);
    end
    for (int i = 0; i < 5; i++) begin
      sweep(1'b0);
      wr(`CTRL_OFFSET, 32'h10 << i);
      repeat (3) @(posedge clk);
      chk({28'h0, statusDigit}, i < 4 ? 32'(i + 4) : 32'h9);
      chk({31'h0, watchdogTimeout}, {31'h0, i > 0});
      wr(`CTRL_OFFSET, 32'h0);
      if (i > 0) clr();
    end
    for (int i = 0; i < 2; i++) begin
      sweep(1'b0);
      {holdSelected, processorFail} <= i[0] ? 2'b01 : 2'b10;
      repeat (6) @(posedge clk);
      {holdSelected, processorFail} <= 2'b00;
      repeat (6) @(posedge clk);
      clr();
    end
    for (int i = 0; i < 2; i++) begin
      scanLimitStrap <= i[0];
      repeat (4) @(posedge clk);
      sweep(1'b0);
      repeat (i ? 250 : 150) @(posedge clk);
      chk({31'h0, watchdogTimeout}, 32'h0);
      repeat (60) @(posedge clk);
      chk({28'h0, statusDigit}, 32'h8);
      sweep(1'b0);
      clr();
    end
    report_and_stop();
  end
endmodule
bind device_switch device_switch_checker #(.FLASH_HALF(FLASH_HALF))
  u_chk (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
  .holdSelected, .backupFlagPlaceStrap, .copyReq, .copyAck, .copyKind,
  .backupFlagInput,
  .firstMasterLed, .secondMasterLed, .relayToNormallyOpen,
  .statusDigit, .statusBlank, .watchdogTimeout);
